// ==== shared/ats_pkg.sv ====
// constants and types for the apdu transport sequencer
// Functional notes
// - card accepts full chained blocks, last 0..max
// - card chain blocks never exceed terminal max; the segmenter caps them at the limit frozen at chain start, 1 when that is 0
// - oversized block rejected, R-block code 2
// - avoid sending empty information blocks; the segmenter still gives one 0-length block when started with total 0
// - status belongs to most recent command
// - case 1: length byte 00, status only
// - card decodes header: case 1 or 2
// - case 2: data via 6Cxx/61xx, else status
// - status only after whole command data
// - case 4 normal answers 61xx, else status
// - retrieval command handled exactly as case 2
// - chained block acknowledged with expected number
package ats_pkg;
    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_CARD_MAX_INFO_SIZE      = 4'h4;
    localparam logic [3:0]  REG_TERMINAL_MAX_INFO_SIZE      = 4'h8;
    localparam logic [3:0]  REG_STAT      = 4'hc;
    localparam int          CTRL_EN       = 0;
    localparam int          STAT_OVER     = 0;
    localparam int          STAT_EMPTY    = 1;
    localparam int          STAT_BUSY     = 2;
    localparam int          STAT_SEG_BUSY = 3;
    localparam int          STAT_PEND_LSB = 8;
    localparam logic        CTRL_EN_RST   = 1'h1;
    localparam logic [7:0]  CARD_MAX_INFO_SIZE_RST      = 8'h20;
    localparam logic [7:0]  TERMINAL_MAX_INFO_SIZE_RST      = 8'h20;
    // ***************************************************
    // link codes
    // ***************************************************
    localparam logic [7:0]  INS_GET_RESP  = 8'hc0;
    localparam logic [7:0]  PB_MORE       = 8'h61;
    localparam logic [7:0]  PB_WRONG_LE   = 8'h6c;
    localparam logic [15:0] SW_OK         = 16'h9000;
    localparam logic [7:0]  RB_PCB_BASE   = 8'h80;
    localparam logic [3:0]  RB_CODE_OK    = 4'h0;
    localparam logic [3:0]  RB_CODE_BADLEN = 4'h2;
    localparam logic [2:0]  HDR_LAST      = 3'h4;
    localparam int          IDX_INS       = 1;
    localparam int          IDX_LEN       = 4;
    localparam logic [8:0]  LE_MAX        = 9'h100;
    localparam logic [7:0]  SEG_CAP_RST   = 8'h01;
    // ***************************************************
    // sequencer states
    // ***************************************************
    typedef enum logic [6:0] {
        ATS_IDLE      = 7'h01,
        ATS_HDR       = 7'h02,
        ATS_DECIDE    = 7'h04,
        ATS_DATA_IN   = 7'h08,
        ATS_PROC      = 7'h10,
        ATS_SEND_DATA = 7'h20,
        ATS_TX        = 7'h40
    } ats_state_t;
endpackage : ats_pkg

// ==== shared/ats_seg_if.sv ====
// link between sequencer and outgoing chain segmenter
`timescale 1ns/1ps
interface ats_seg_if;
    logic        clk;
    logic        rst;
    logic [7:0]  terminal_max_info_size;
    logic        start;
    logic [15:0] total;
    logic        next;
    logic [7:0]  blen;
    logic        more;
    logic        busy;
    modport seg (input clk, rst, terminal_max_info_size, start, total, next, output blen, more, busy);
    modport ctl (output clk, rst, terminal_max_info_size, start, total, next, input blen, more, busy);
endinterface : ats_seg_if

// ==== hdl/ats_seg.sv ====
// splits an outgoing response into chained block lengths
`timescale 1ns/1ps
module ats_seg
    import ats_pkg::*;
(
    ats_seg_if.seg s
);
    logic [15:0] rem;
    logic [7:0]  cap;
    logic [15:0] src;
    logic [7:0]  lim;
    logic        next_more;
    logic [7:0]  next_len;

    // the limit is frozen at chain start so a mid-chain change cannot shrink a block
    always_comb begin
        src       = s.busy ? rem : s.total;
        lim       = s.busy ? cap : ((s.terminal_max_info_size == 8'h00) ? SEG_CAP_RST : s.terminal_max_info_size);
        next_more = src > {8'h00, lim};
        next_len  = next_more ? lim : src[7:0];
    end

    always_ff @(posedge s.clk) begin
        if (s.rst) begin
            rem    <= 16'h0000;
            cap    <= SEG_CAP_RST;
            s.busy <= 1'h0;
            s.blen <= 8'h00;
            s.more <= 1'h0;
        end else if (!s.busy && s.start) begin
            cap    <= lim;
            s.busy <= 1'h1;
            s.blen <= next_len;
            s.more <= next_more;
            rem    <= src - {8'h00, next_len};
        end else if (s.busy && s.next) begin
            if (!s.more) begin
                s.busy <= 1'h0;
            end else begin
                s.blen <= next_len;
                s.more <= next_more;
                rem    <= src - {8'h00, next_len};
            end
        end
    end

    a_seg_cap: assert property (@(posedge s.clk) disable iff (s.rst) s.busy |-> s.blen <= cap)
        else $error("chain block longer than terminal limit");
    a_seg_split: assert property (@(posedge s.clk) disable iff (s.rst)
        (!s.busy && s.start && s.total > {8'h00, lim}) |=> s.more && s.blen == $past(lim))
        else $error("long response not split at terminal limit");
endmodule : ats_seg

// ==== hdl/ats_seq.sv ====
// card-side transport sequencer: block chaining checks and command/response steering
`timescale 1ns/1ps
module ats_seq
    import ats_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_BYTE,
    input  wire logic        TX_READY,
    output logic             TX_VALID,
    output logic      [7:0]  TX_BYTE,
    output logic             HDR_VALID,
    output logic      [39:0] HDR_DATA,
    input  wire logic        APP_RESP,
    input  wire logic        APP_NORMAL,
    input  wire logic        APP_IN,
    input  wire logic        APP_OUT,
    input  wire logic [8:0]  APP_AVAIL,
    input  wire logic [15:0] APP_SW,
    input  wire logic [7:0]  APP_DATA,
    output logic             IN_VALID,
    output logic      [7:0]  IN_BYTE,
    output logic             IN_DONE,
    output logic             OUT_TAKE,
    input  wire logic        BLK_VALID,
    input  wire logic [7:0]  BLK_LEN,
    input  wire logic        BLK_MORE,
    input  wire logic        BLK_NS,
    output logic             BLK_ACCEPT,
    output logic             RB_VALID,
    output logic      [7:0]  RB_PCB,
    input  wire logic        TXC_START,
    input  wire logic [15:0] TXC_TOTAL,
    input  wire logic        TXC_NEXT,
    output logic      [7:0]  TXC_LEN,
    output logic             TXC_MORE,
    output logic             TXC_BUSY
);
    // ***************************************************
    // declarations
    // ***************************************************
    ats_state_t  state;
    ats_state_t  q_ret;
    logic [7:0]  hdr [5];
    logic [2:0]  hcnt;
    logic [8:0]  dcnt;
    logic [8:0]  pend;
    logic [8:0]  tot;
    logic [8:0]  le;
    logic [15:0] sw_hold;
    logic        int_gr;
    logic        c_out;
    logic [7:0]  q_hi;
    logic [7:0]  q_lo;
    logic        q_two;
    logic        q_idx;
    logic        ctrl_en;
    logic [7:0]  card_max_info_size;
    logic [7:0]  terminal_max_info_size;
    logic        stat_over;
    logic        stat_empty;
    logic        ns_exp;
    logic [8:0]  p3_le;
    logic        dec_ready;
    logic        dec_normal;
    logic        dec_in;
    logic        dec_out;
    logic [8:0]  dec_avail;
    logic [15:0] dec_sw;
    logic        next_gr;

    ats_seg_if segb ();

    // ***************************************************
    // outgoing chain segmenter
    // ***************************************************
    assign segb.clk   = REF_CLK;
    assign segb.rst   = RST;
    assign segb.terminal_max_info_size  = terminal_max_info_size;
    assign segb.start = TXC_START;
    assign segb.total = TXC_TOTAL;
    assign segb.next  = TXC_NEXT;
    assign TXC_LEN    = segb.blen;
    assign TXC_MORE   = segb.more;
    assign TXC_BUSY   = segb.busy;

    ats_seg u_seg (
        .s (segb.seg)
    );

    // ***************************************************
    // header decode
    // ***************************************************
    // a retrieval with nothing pending goes to the processor, which may still hold data
    assign next_gr    = (hdr[IDX_INS] == INS_GET_RESP) && (pend != 9'h000);
    assign p3_le      = (hdr[IDX_LEN] == 8'h00) ? LE_MAX : {1'h0, hdr[IDX_LEN]};
    assign dec_ready  = int_gr | APP_RESP;
    assign dec_normal = int_gr | APP_NORMAL;
    assign dec_in     = !int_gr & APP_IN;
    assign dec_out    = int_gr | APP_OUT;
    assign dec_avail  = int_gr ? pend : APP_AVAIL;
    assign dec_sw     = int_gr ? SW_OK : APP_SW;

    // ***************************************************
    // command sequencer
    // ***************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state   <= ATS_IDLE;
            q_ret   <= ATS_IDLE;
            hcnt    <= 3'h0;
            dcnt    <= 9'h000;
            pend    <= 9'h000;
            tot     <= 9'h000;
            le      <= 9'h000;
            sw_hold <= 16'h0000;
            int_gr  <= 1'h0;
            c_out   <= 1'h0;
            q_hi    <= 8'h00;
            q_lo    <= 8'h00;
            q_two   <= 1'h0;
            q_idx   <= 1'h0;
        end else begin
            unique case (state)
                ATS_IDLE: begin
                    if (RX_VALID && ctrl_en) begin
                        hcnt  <= 3'h1;
                        state <= ATS_HDR;
                    end
                end
                ATS_HDR: begin
                    if (RX_VALID) begin
                        hcnt <= hcnt + 3'h1;
                        if (hcnt == HDR_LAST) begin
                            int_gr <= next_gr;
                            hcnt   <= 3'h0; // next header's first byte lands at index 0
                            state  <= ATS_DECIDE;
                            if (!next_gr) begin
                                pend <= 9'h000;
                            end
                        end
                    end
                end
                ATS_DECIDE: begin
                    if (dec_ready) begin
                        sw_hold <= dec_sw;
                        tot     <= dec_avail;
                        le      <= p3_le;
                        c_out   <= dec_out;
                        q_idx   <= 1'h0;
                        state   <= ATS_TX;
                        if (!dec_normal || (!dec_in && !dec_out)) begin
                            {q_hi, q_lo} <= dec_sw;
                            q_two        <= 1'h1;
                            q_ret        <= ATS_IDLE;
                        end else if (dec_in) begin
                            q_hi  <= hdr[IDX_INS];
                            q_two <= 1'h0;
                            q_ret <= ATS_DATA_IN;
                            dcnt  <= {1'h0, hdr[IDX_LEN]};
                        end else if (p3_le > dec_avail) begin
                            q_hi  <= PB_WRONG_LE;
                            q_lo  <= dec_avail[7:0];
                            q_two <= 1'h1;
                            q_ret <= ATS_IDLE;
                        end else begin
                            q_hi  <= hdr[IDX_INS];
                            q_two <= 1'h0;
                            q_ret <= ATS_SEND_DATA;
                            dcnt  <= p3_le;
                        end
                    end
                end
                ATS_DATA_IN: begin
                    if (dcnt == 9'h000) begin
                        state <= ATS_PROC;
                    end else if (RX_VALID) begin
                        dcnt <= dcnt - 9'h001;
                    end
                end
                ATS_PROC: begin
                    if (APP_RESP) begin
                        q_two <= 1'h1;
                        q_idx <= 1'h0;
                        q_ret <= ATS_IDLE;
                        state <= ATS_TX;
                        if (c_out && APP_NORMAL) begin
                            q_hi <= PB_MORE;
                            q_lo <= APP_AVAIL[7:0];
                            pend <= APP_AVAIL;
                        end else begin
                            {q_hi, q_lo} <= APP_SW;
                        end
                    end
                end
                ATS_SEND_DATA: begin
                    if (TX_READY) begin
                        dcnt <= dcnt - 9'h001;
                        if (dcnt == 9'h001) begin
                            q_two <= 1'h1;
                            q_idx <= 1'h0;
                            q_ret <= ATS_IDLE;
                            state <= ATS_TX;
                            if (tot != le) begin
                                q_hi <= PB_MORE;
                                q_lo <= 8'(tot - le);
                                pend <= tot - le;
                            end else begin
                                {q_hi, q_lo} <= int_gr ? SW_OK : sw_hold;
                                pend         <= 9'h000;
                            end
                        end
                    end
                end
                ATS_TX: begin
                    if (TX_READY) begin
                        if (q_two && !q_idx) begin
                            q_idx <= 1'h1;
                        end else begin
                            q_idx <= 1'h0;
                            state <= q_ret;
                        end
                    end
                end
            endcase
        end
    end

    // header bytes are stored by index
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            for (int i = 0; i < 5; i++) begin
                hdr[i] <= 8'h00;
            end
        end else if ((state == ATS_IDLE && ctrl_en) || state == ATS_HDR) begin
            if (RX_VALID) begin
                hdr[hcnt] <= RX_BYTE;
            end
        end
    end

    // ***************************************************
    // link and processor strobes
    // ***************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            TX_VALID  <= 1'h0;
            TX_BYTE   <= 8'h00;
            OUT_TAKE  <= 1'h0;
            HDR_VALID <= 1'h0;
            HDR_DATA  <= 40'h0;
            IN_VALID  <= 1'h0;
            IN_BYTE   <= 8'h00;
            IN_DONE   <= 1'h0;
        end else begin
            TX_VALID  <= 1'h0;
            OUT_TAKE  <= 1'h0;
            HDR_VALID <= 1'h0;
            IN_VALID  <= 1'h0;
            IN_DONE   <= 1'h0;
            if (state == ATS_TX && TX_READY) begin
                TX_VALID <= 1'h1;
                TX_BYTE  <= q_idx ? q_lo : q_hi;
            end
            if (state == ATS_SEND_DATA && TX_READY) begin
                TX_VALID <= 1'h1;
                TX_BYTE  <= APP_DATA;
                OUT_TAKE <= 1'h1;
            end
            if (state == ATS_HDR && RX_VALID && hcnt == HDR_LAST) begin
                HDR_VALID <= !next_gr;
                HDR_DATA  <= {hdr[0], hdr[1], hdr[2], hdr[3], RX_BYTE};
            end
            if (state == ATS_DATA_IN && dcnt != 9'h000 && RX_VALID) begin
                IN_VALID <= 1'h1;
                IN_BYTE  <= RX_BYTE;
            end
            IN_DONE <= (state == ATS_DATA_IN) && (dcnt == 9'h000);
        end
    end

    // ***************************************************
    // incoming block checks
    // ***************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ns_exp     <= 1'h0;
            BLK_ACCEPT <= 1'h0;
            RB_VALID   <= 1'h0;
            RB_PCB     <= 8'h00;
        end else begin
            BLK_ACCEPT <= 1'h0;
            RB_VALID   <= 1'h0;
            if (BLK_VALID) begin
                if (BLK_LEN > card_max_info_size) begin
                    RB_VALID <= 1'h1;
                    RB_PCB   <= RB_PCB_BASE | {3'h0, ns_exp, RB_CODE_BADLEN};
                end else begin
                    BLK_ACCEPT <= 1'h1;
                    ns_exp     <= ~BLK_NS;
                    if (BLK_MORE) begin
                        RB_VALID <= 1'h1;
                        RB_PCB   <= RB_PCB_BASE | {3'h0, ~BLK_NS, RB_CODE_OK};
                    end
                end
            end
        end
    end

    // sticky flags: a new event in the clearing cycle wins
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            stat_over  <= 1'h0;
            stat_empty <= 1'h0;
        end else begin
            if (WR && ADDR == REG_STAT && WDATA[STAT_OVER]) begin
                stat_over <= 1'h0;
            end
            if (WR && ADDR == REG_STAT && WDATA[STAT_EMPTY]) begin
                stat_empty <= 1'h0;
            end
            if (BLK_VALID && BLK_LEN > card_max_info_size) begin
                stat_over <= 1'h1;
            end
            if (BLK_VALID && BLK_LEN == 8'h00) begin
                stat_empty <= 1'h1;
            end
        end
    end

    // ***************************************************
    // register port
    // ***************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ctrl_en <= CTRL_EN_RST;
            card_max_info_size    <= CARD_MAX_INFO_SIZE_RST;
            terminal_max_info_size    <= TERMINAL_MAX_INFO_SIZE_RST;
        end else if (WR) begin
            unique case (ADDR)
                REG_CTRL: ctrl_en <= WDATA[CTRL_EN];
                REG_CARD_MAX_INFO_SIZE: card_max_info_size    <= WDATA[7:0];
                REG_TERMINAL_MAX_INFO_SIZE: terminal_max_info_size    <= WDATA[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RDATA <= 32'h0;
        end else begin
            RDATA <= 32'h0;
            if (RD) begin
                unique case (ADDR)
                    REG_CTRL: RDATA[CTRL_EN] <= ctrl_en;
                    REG_CARD_MAX_INFO_SIZE: RDATA[7:0]     <= card_max_info_size;
                    REG_TERMINAL_MAX_INFO_SIZE: RDATA[7:0]     <= terminal_max_info_size;
                    REG_STAT: begin
                        RDATA[STAT_OVER]                    <= stat_over;
                        RDATA[STAT_EMPTY]                   <= stat_empty;
                        RDATA[STAT_BUSY]                    <= state != ATS_IDLE;
                        RDATA[STAT_SEG_BUSY]                <= segb.busy;
                        RDATA[STAT_PEND_LSB +: 9]           <= pend;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_over;
        BLK_VALID && BLK_LEN > card_max_info_size;
    endsequence
    sequence s_c4_ok;
        state == ATS_PROC && APP_RESP && c_out && APP_NORMAL;
    endsequence
    sequence s_gr_end;
        state == ATS_SEND_DATA && TX_READY && dcnt == 9'h001 && int_gr && tot == le;
    endsequence

    a_oversize_reject: assert property (s_over |=> RB_VALID && RB_PCB[3:0] == RB_CODE_BADLEN && !BLK_ACCEPT)
        else $error("oversized block not rejected");
    a_block_accept: assert property ((BLK_VALID && BLK_LEN <= card_max_info_size) |=> BLK_ACCEPT)
        else $error("legal block not accepted");
    a_chain_ack: assert property ((BLK_VALID && BLK_LEN <= card_max_info_size && BLK_MORE)
        |=> RB_VALID && RB_PCB[3:0] == RB_CODE_OK && RB_PCB[4] == !$past(BLK_NS))
        else $error("chained block not acknowledged");
    a_empty_flag: assert property ((BLK_VALID && BLK_LEN == 8'h00) |=> stat_empty)
        else $error("empty block not flagged");
    a_status_only: assert property ((state == ATS_DECIDE && dec_ready && !dec_in && !dec_out)
        |=> state == ATS_TX && q_two && {q_hi, q_lo} == $past(dec_sw))
        else $error("case 1 answer is not status");
    a_wrong_le: assert property ((state == ATS_DECIDE && dec_ready && dec_normal && !dec_in && dec_out
        && p3_le > dec_avail) |=> q_hi == PB_WRONG_LE && q_lo == $past(dec_avail[7:0]))
        else $error("wrong length not answered with 6c");
    a_data_hold: assert property ((state == ATS_DATA_IN && $past(state) == ATS_DATA_IN) |-> !TX_VALID)
        else $error("card spoke before command data ended");
    a_case4_more: assert property (s_c4_ok |=> q_hi == PB_MORE && q_lo == $past(APP_AVAIL[7:0])
        && pend == $past(APP_AVAIL))
        else $error("case 4 did not request retrieval");
    a_gr_status: assert property (s_gr_end |=> {q_hi, q_lo} == SW_OK && pend == 9'h000)
        else $error("retrieval status wrong");
endmodule : ats_seq

// ==== verif/ats_term.sv ====
// terminal link model: sends bytes to the card, collects card bytes
`timescale 1ns/1ps
module ats_term (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            tx_ready
);
    logic [7:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
        tx_ready = 1'b1;
    end
    // card bytes end here, nothing goes upward
    always @(posedge clk) if (tx_valid) got.push_back(tx_byte);
    // link stalls every other cycle so the card's wait on ready is exercised
    always @(posedge clk) tx_ready <= ~tx_ready;
    task automatic put(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_byte  <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte  <= ~b; // no stale byte left on the idle line
    endtask : put
endmodule : ats_term

// ==== verif/ats_bench.sv ====
// self-checking bench for the card-side transport sequencer
`timescale 1ns/1ps
module apdu_transport_sequencer_bench;
    import ats_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, rxv, txr, txv, hv, ar = 0, an = 1, ai = 0, ao = 0;
    logic iv, idn, ot, bv = 0, bm = 0, bns = 0, ba, rbv, ts = 0, tn = 0, tm, tb;
    logic [3:0] ad = 0;
    logic [31:0] wd = 0, rdt, v;
    logic [7:0] rxb, txb, ib, bl = 0, pcb, tl;
    logic [39:0] hd;
    logic [8:0] av = 0;
    logic [15:0] sw = 0, tt = 0;
    int num_errors = 0, checks_done = 0;
    int n_in = 0, n_out = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (iv === 1'b1) n_in++;
        if (ot === 1'b1) n_out++;
    end
    ats_term u_term (.clk(clk), .tx_valid(txv), .tx_byte(txb), .rx_valid(rxv), .rx_byte(rxb), .tx_ready(txr));
    ats_seq u_dut (.REF_CLK(clk), .RST(rst), .ADDR(ad), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdt),
        .RX_VALID(rxv), .RX_BYTE(rxb), .TX_READY(txr), .TX_VALID(txv), .TX_BYTE(txb), .HDR_VALID(hv),
        .HDR_DATA(hd), .APP_RESP(ar), .APP_NORMAL(an), .APP_IN(ai), .APP_OUT(ao), .APP_AVAIL(av),
        .APP_SW(sw), .APP_DATA(8'h5a), .IN_VALID(iv), .IN_BYTE(ib), .IN_DONE(idn), .OUT_TAKE(ot),
        .BLK_VALID(bv), .BLK_LEN(bl), .BLK_MORE(bm), .BLK_NS(bns), .BLK_ACCEPT(ba), .RB_VALID(rbv),
        .RB_PCB(pcb), .TXC_START(ts), .TXC_TOTAL(tt), .TXC_NEXT(tn), .TXC_LEN(tl), .TXC_MORE(tm),
        .TXC_BUSY(tb));
    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        v = rdt;
    endtask : bus
    task automatic poll(ref logic s);
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            if (s === 1'b1) break;
        end
        if (s !== 1'b1) num_errors++;
    endtask : poll
    task automatic resp(input logic i, input logic o, input logic [15:0] w, input logic [8:0] a);
        ar <= 1'b1;
        ai <= i;
        ao <= o;
        sw <= w;
        av <= a;
        @(posedge clk);
        ar <= 1'b0;
    endtask : resp
    task automatic wt(input int n);
        for (int i = 0; i < 300 && u_term.got.size() < n; i++) @(posedge clk);
        if (u_term.got.size() < n) num_errors++;
    endtask : wt
    // one command: header, processor answer unless own, optional data body, then n card bytes
    task automatic cmd(input logic [39:0] h, input logic i, input logic o, input logic own, input int n,
        input logic [15:0] fs);
        int b_in;
        int b_out;
        b_in = n_in;
        b_out = n_out;
        u_term.got.delete();
        for (int k = 4; k >= 0; k--) u_term.put(h[8*k +: 8]);
        if (!own) poll(hv);
        if (!own) chk(hd, h);
        if (!own) resp(i, o, 16'h6a82, 9'h008);
        if (i) begin
            wt(1);
            for (int k = 0; k < h[7:0]; k++) u_term.put(8'(k));
            poll(idn);
            chk(n_in - b_in, h[7:0]);
            chk(ib, h[7:0] - 8'h01);
            an <= (fs == SW_OK);
            resp(1'b0, 1'b1, fs, 9'h005);
            an <= 1'b1;
        end
        wt(n);
        chk(n_out - b_out, own ? h[7:0] : 8'h00);
    endtask : cmd
    task automatic blk(input logic [7:0] l, input logic m, input logic s, input logic [9:0] e);
        @(posedge clk);
        bv <= 1'b1;
        bl <= l;
        bm <= m;
        bns <= s;
        @(posedge clk);
        bv <= 1'b0;
        #1;
        chk({ba, rbv, rbv ? pcb : 8'h00}, e);
    endtask : blk
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(0, REG_CTRL, 0);
        chk(v, 32'h1);
        bus(0, REG_CARD_MAX_INFO_SIZE, 0);
        chk(v, 32'h20);
        bus(0, 4'h2, 0);
        chk(v, 32'h0);
        blk(8'h20, 1, 0, 10'h390);
        blk(8'h21, 1, 1, 10'h192);
        blk(8'h00, 0, 1, 10'h200);
        bus(0, REG_STAT, 0);
        chk(v[1:0], 2'h3);
        bus(1, REG_STAT, 32'h3);
        bus(0, REG_STAT, 0);
        chk(v[3:0], 4'h0);
        an <= 1'b0;
        cmd(40'h00a4000000, 0, 0, 0, 2, SW_OK);
        chk({u_term.got[0], u_term.got[1]}, 16'h6a82);
        an <= 1'b1;
        cmd(40'h80b2000010, 0, 1, 0, 2, SW_OK);
        chk({u_term.got[0], u_term.got[1]}, 16'h6c08);
        cmd(40'h00a4000002, 1, 1, 0, 3, SW_OK);
        chk({u_term.got[0], u_term.got[1], u_term.got[2]}, 24'ha46105);
        bus(0, REG_STAT, 0);
        chk(v[16:8], 9'h005);
        cmd(40'h00c0000005, 0, 1, 1, 8, SW_OK);
        chk({u_term.got[0], u_term.got[5], u_term.got[6], u_term.got[7]}, 32'hc05a9000);
        cmd(40'h00a4000002, 1, 1, 0, 3, 16'h6283);
        chk({u_term.got[0], u_term.got[1], u_term.got[2]}, 24'ha46283);
        cmd(40'h00c0000000, 0, 1, 0, 2, SW_OK);
        chk({u_term.got[0], u_term.got[1]}, 16'h6c08);
        bus(1, REG_TERMINAL_MAX_INFO_SIZE, 32'h10);
        tt <= 16'h0025;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            ts <= (k == 0);
            tn <= (k != 0);
            @(posedge clk);
            ts <= 1'b0;
            tn <= 1'b0;
            @(posedge clk);
            #1;
            chk(k < 3 ? {tb, tm, tl} : {tb, 9'h0}, k < 2 ? 10'h310 : (k == 2 ? 10'h205 : 10'h0));
        end
        wrap_up();
    end
endmodule : apdu_transport_sequencer_bench
